/* File: rtl/sscr_pkg.sv */
// package for the socket supply control register block
// assumes a 32-bit classic wishbone slave with byte addresses
package sscr_pkg;
  localparam logic [7:0] SSCR_OFFSET = 8'h10;
  localparam logic [31:0] SSCR_RESET = 32'h0000_0400;
  localparam int SSCR_ACT_BIT = 11;
  localparam int SSCR_STDV_BIT = 10;
  localparam int SSCR_VIDEO_PORT_ENABLE_BIT = 9;
  localparam int SSCR_STOP_BIT = 7;
  localparam int SSCR_VCC_LSB = 4;
  localparam int SSCR_VPP_LSB = 0;
  localparam logic [2:0] SSCR_SUP_OFF = 3'h0;
  localparam logic [2:0] SSCR_VPP_12V = 3'h1;
  localparam logic [2:0] SSCR_SUP_5V = 3'h2;
  localparam logic [2:0] SSCR_SUP_3V3 = 3'h3;
  localparam logic [2:0] SSCR_SUP_XV = 3'h4;
  localparam logic [2:0] SSCR_SUP_YV = 3'h5;
  localparam logic [4:0] SSCR_SLOW_DIV = 5'h10;
  // card voltage class flags: {y, x, low(3.3), high(5)}
  typedef struct packed {
    logic class_y;
    logic class_x;
    logic class_low;
    logic class_high;
  } sscr_vclass_t;
  typedef struct packed {
    logic [2:0] card_supply;
    logic [2:0] program_supply;
  } sscr_supply_t;
endpackage

/* File: rtl/sscr_top.sv */
// socket supply control register with supply gating and card clock-run control
// assumes classic wishbone master on clk; card status inputs come from pins
`timescale 1ns/1ps
module sscr_top
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic standard_video_model_disable,
  input wire logic force_class_write,
  input wire logic [3:0] force_class_bits,
  input wire logic card_reinterrogate,
  input wire logic clock_control_enable,
  input wire logic clock_slow_select,
  input wire logic card_present_pin,
  input wire logic [3:0] card_class_pin,
  input wire logic socket_idle,
  input wire logic host_clk_stop_prep,
  output logic [2:0] card_supply_out,
  output logic [2:0] program_supply_out,
  output logic supply_refused,
  output logic video_port_on,
  output logic card_clk_stop,
  output logic card_clk_slow,
  output logic card_clk_en
);
  // pin synchronisers: first stage read only by second stage
  logic card_present_s1_r, card_present_s2_r;
  logic [3:0] card_class_s1_r, card_class_s2_r;

  // register state
  logic video_port_enable_r, video_port_enable_nxt;
  logic clock_stop_policy_r, clock_stop_policy_nxt;
  logic [2:0] card_supply_request_r, card_supply_request_nxt;
  logic [2:0] program_supply_request_r, program_supply_request_nxt;
  logic reg_enabled_r, reg_enabled_nxt;
  sscr_pkg::sscr_vclass_t card_class_r, card_class_nxt;
  logic [31:0] wb_dat_nxt;
  logic wb_ack_nxt;

  // outputs and slow-clock counter
  logic [2:0] card_supply_nxt, program_supply_nxt;
  logic supply_refused_nxt, video_port_on_nxt;
  logic card_clk_stop_nxt, card_clk_slow_nxt, card_clk_en_nxt;
  logic [4:0] slow_cnt_r, slow_cnt_nxt;

  logic hit, wr_lo, wr_hi, vcc_ok, vpp_ok;
  logic [2:0] vcc_eff, vpp_eff;
  logic stop_allowed;
  logic [31:0] rd_word;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      card_present_s1_r <= 1'b0;
      card_present_s2_r <= 1'b0;
      card_class_s1_r <= 4'h0;
      card_class_s2_r <= 4'h0;
    end
    else
    begin
      card_present_s1_r <= card_present_pin;
      card_present_s2_r <= card_present_s1_r;
      card_class_s1_r <= card_class_pin;
      card_class_s2_r <= card_class_s1_r;
    end
  end

  assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lo = hit && wb_we_i && wb_adr_i == sscr_pkg::SSCR_OFFSET && wb_sel_i[0];
  assign wr_hi = hit && wb_we_i && wb_adr_i == sscr_pkg::SSCR_OFFSET && wb_sel_i[1];

  // read word: reserved bits, 31..12, 8 and 3 are constant zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_word[sscr_pkg::SSCR_ACT_BIT] = video_port_enable_r;
    rd_word[sscr_pkg::SSCR_STDV_BIT] = !standard_video_model_disable;
    rd_word[sscr_pkg::SSCR_VIDEO_PORT_ENABLE_BIT] = video_port_enable_r;
    rd_word[sscr_pkg::SSCR_STOP_BIT] = clock_stop_policy_r;
    rd_word[sscr_pkg::SSCR_VCC_LSB +: 3] = card_supply_request_r;
    rd_word[sscr_pkg::SSCR_VPP_LSB +: 3] = program_supply_request_r;
  end

  // register bus and control state
  always_comb
  begin
    video_port_enable_nxt = video_port_enable_r;
    clock_stop_policy_nxt = clock_stop_policy_r;
    card_supply_request_nxt = card_supply_request_r;
    program_supply_request_nxt = program_supply_request_r;
    reg_enabled_nxt = reg_enabled_r;
    card_class_nxt = card_class_r;
    wb_ack_nxt = hit;
    wb_dat_nxt = 32'h0000_0000;
    if (hit && !wb_we_i && wb_adr_i == sscr_pkg::SSCR_OFFSET)
      wb_dat_nxt = rd_word;
    if (wr_lo)
    begin
      clock_stop_policy_nxt = wb_dat_i[sscr_pkg::SSCR_STOP_BIT];
      card_supply_request_nxt = wb_dat_i[sscr_pkg::SSCR_VCC_LSB +: 3];
      program_supply_request_nxt = wb_dat_i[sscr_pkg::SSCR_VPP_LSB +: 3];
    end
    if (wr_hi)
      video_port_enable_nxt = wb_dat_i[sscr_pkg::SSCR_VIDEO_PORT_ENABLE_BIT];
    // forced class overrides detected class and disables the register
    if (force_class_write && force_class_bits != 4'h0)
    begin
      card_class_nxt = force_class_bits;
      reg_enabled_nxt = 1'b0;
    end
    // reinterrogate wins over a simultaneous force
    if (card_reinterrogate)
    begin
      card_class_nxt = card_class_s2_r;
      reg_enabled_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      video_port_enable_r <= 1'b0;
      clock_stop_policy_r <= 1'b0;
      card_supply_request_r <= sscr_pkg::SSCR_SUP_OFF;
      program_supply_request_r <= sscr_pkg::SSCR_SUP_OFF;
      reg_enabled_r <= 1'b1;
      card_class_r <= 4'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      video_port_enable_r <= video_port_enable_nxt;
      clock_stop_policy_r <= clock_stop_policy_nxt;
      card_supply_request_r <= card_supply_request_nxt;
      program_supply_request_r <= program_supply_request_nxt;
      reg_enabled_r <= reg_enabled_nxt;
      card_class_r <= card_class_nxt;
      wb_ack_o <= wb_ack_nxt;
      wb_dat_o <= wb_dat_nxt;
    end
  end

  // supply decode and class check
  always_comb
  begin
    unique case (card_supply_request_r)
      sscr_pkg::SSCR_SUP_5V: vcc_ok = card_class_r.class_high;
      sscr_pkg::SSCR_SUP_3V3: vcc_ok = card_class_r.class_low;
      sscr_pkg::SSCR_SUP_XV: vcc_ok = card_class_r.class_x;
      sscr_pkg::SSCR_SUP_YV: vcc_ok = card_class_r.class_y;
      default: vcc_ok = 1'b0;
    endcase
    unique case (program_supply_request_r)
      sscr_pkg::SSCR_VPP_12V: vpp_ok = 1'b1;
      sscr_pkg::SSCR_SUP_5V: vpp_ok = card_class_r.class_high;
      sscr_pkg::SSCR_SUP_3V3: vpp_ok = card_class_r.class_low;
      sscr_pkg::SSCR_SUP_XV: vpp_ok = card_class_r.class_x;
      sscr_pkg::SSCR_SUP_YV: vpp_ok = card_class_r.class_y;
      default: vpp_ok = 1'b0;
    endcase
    // without a card there is no class to honour: keep supplies off while the register is enabled
    vcc_ok = vcc_ok && card_present_s2_r;
    vpp_ok = vpp_ok && card_present_s2_r;
    // while disabled the applied supplies stay as they were: cutting them would drop the card
    vcc_eff = card_supply_out;
    vpp_eff = program_supply_out;
    if (reg_enabled_r)
    begin
      vcc_eff = vcc_ok ? card_supply_request_r : sscr_pkg::SSCR_SUP_OFF;
      vpp_eff = vpp_ok ? program_supply_request_r : sscr_pkg::SSCR_SUP_OFF;
    end
    card_supply_nxt = vcc_eff;
    program_supply_nxt = vpp_eff;
    supply_refused_nxt = reg_enabled_r && card_present_s2_r &&
      ((card_supply_request_r != sscr_pkg::SSCR_SUP_OFF && !vcc_ok) ||
       (program_supply_request_r != sscr_pkg::SSCR_SUP_OFF && !vpp_ok));
    video_port_on_nxt = video_port_enable_r;
  end

  // card clock-run: stop, or slow by 16 as a one-in-sixteen clock enable
  always_comb
  begin
    stop_allowed = socket_idle && (clock_stop_policy_r || host_clk_stop_prep);
    card_clk_stop_nxt = stop_allowed && !(clock_control_enable && clock_slow_select);
    card_clk_slow_nxt = stop_allowed && clock_control_enable && clock_slow_select;
    slow_cnt_nxt = 5'h00;
    if (card_clk_slow_nxt)
      slow_cnt_nxt = (slow_cnt_r == sscr_pkg::SSCR_SLOW_DIV - 5'h01) ? 5'h00 : slow_cnt_r + 5'h01;
    card_clk_en_nxt = !card_clk_stop_nxt && (!card_clk_slow_nxt || slow_cnt_r == 5'h00);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      card_supply_out <= sscr_pkg::SSCR_SUP_OFF;
      program_supply_out <= sscr_pkg::SSCR_SUP_OFF;
      supply_refused <= 1'b0;
      video_port_on <= 1'b0;
      card_clk_stop <= 1'b0;
      card_clk_slow <= 1'b0;
      card_clk_en <= 1'b1;
      slow_cnt_r <= 5'h00;
    end
    else
    begin
      card_supply_out <= card_supply_nxt;
      program_supply_out <= program_supply_nxt;
      supply_refused <= supply_refused_nxt;
      video_port_on <= video_port_on_nxt;
      card_clk_stop <= card_clk_stop_nxt;
      card_clk_slow <= card_clk_slow_nxt;
      card_clk_en <= card_clk_en_nxt;
      slow_cnt_r <= slow_cnt_nxt;
    end
  end
endmodule

/* File: verification/sscr_checker.sv */
// port checker for the socket supply control register
// assumes it is bound to sscr_top and sees only its ports
`timescale 1ns/1ps
module sscr_checker
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic standard_video_model_disable,
  input wire logic clock_control_enable,
  input wire logic clock_slow_select,
  input wire logic socket_idle,
  input wire logic [2:0] card_supply_out,
  input wire logic [2:0] program_supply_out,
  input wire logic card_clk_stop,
  input wire logic card_clk_slow,
  input wire logic card_clk_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_hit;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == sscr_pkg::SSCR_OFFSET;
  endsequence
  AST_ACK: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  AST_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:12] == 20'h0 && !wb_dat_o[8] && !wb_dat_o[3])
    else $error("reserved bit set");
  AST_ACT: assert property (wb_ack_o |-> wb_dat_o[11] == wb_dat_o[9]) else $error("activity");
  AST_STDV: assert property (s_rd_hit |-> wb_dat_o[10] == !$past(standard_video_model_disable))
    else $error("video model flag");
  AST_UNMAP: assert property (wb_ack_o && $past(wb_adr_i) != sscr_pkg::SSCR_OFFSET |-> wb_dat_o == 32'h0)
    else $error("unmapped read");
  AST_IDLE: assert property (card_clk_stop || card_clk_slow |-> $past(socket_idle))
    else $error("clock cut while busy");
  AST_SLOW: assert property (card_clk_slow |-> $past(clock_control_enable && clock_slow_select))
    else $error("slow not selected");
  AST_RSVD: assert property (!(card_supply_out inside {3'h1, 3'h6, 3'h7}) && program_supply_out < 3'h6)
    else $error("reserved supply applied");
  AST_STOPEN: assert property (card_clk_stop |-> !card_clk_en) else $error("clock runs when stopped");
endmodule
bind sscr_top sscr_checker sscr_checker_inst (.*);

/* File: verification/sscr_card_model.sv */
// behavioural inserted card: present, fixed voltage class, idle unless busy
// assumes class and busy are set by the bench
`timescale 1ns/1ps
module sscr_card_model
(
  input wire logic clk,
  input wire logic [3:0] card_class,
  input wire logic busy,
  output logic card_present_pin,
  output logic [3:0] card_class_pin,
  output logic socket_idle
);
  always_ff @(posedge clk)
  begin
    card_present_pin <= 1'b1;
    card_class_pin <= card_class;
    socket_idle <= !busy;
  end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for sscr_top over classic wishbone
// assumes sscr_card_model as the socket side
`timescale 1ns/1ps
module tb_top;
  logic clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy;
  logic standard_video_model_disable, force_class_write, card_reinterrogate;
  logic clock_control_enable, clock_slow_select, card_present_pin, socket_idle;
  logic host_clk_stop_prep, supply_refused, video_port_on;
  logic card_clk_stop, card_clk_slow, card_clk_en;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, force_class_bits, card_class_pin, card_class;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [2:0] card_supply_out, program_supply_out;
  int bad_count, n_tests, k;
  sscr_top sscr_top_inst (.*);
  sscr_card_model sscr_card_model_inst (.*);
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
      @(posedge clk);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    if (n == 20)
    begin
      bad_count++;
      end_sim;
    end
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task reint;
    @(posedge clk);
    card_reinterrogate <= 1'b1;
    @(posedge clk);
    card_reinterrogate <= 1'b0;
  endtask
  task t_regs;
    wb(0, 8'h10, 4'hf, 0);
    chk(q, sscr_pkg::SSCR_RESET);
    wb(1, 8'h14, 4'hf, 32'hffff_ffff);
    wb(0, 8'h14, 4'hf, 0);
    chk(q, 0);
    wb(1, 8'h10, 4'hf, 32'hffff_ffff);
    wb(0, 8'h10, 4'hf, 0);
    chk(q, 32'h0000_0ef7);
    settle;
    chk({video_port_on, card_supply_out, program_supply_out}, 7'h40);
    standard_video_model_disable <= 1'b1;
    wb(0, 8'h10, 4'hf, 0);
    chk(q, 32'h0000_0af7);
  endtask
  task t_supply;
    reint;
    wb(1, 8'h10, 4'hf, 32'h31);
    settle;
    chk({card_supply_out, program_supply_out, supply_refused}, 7'h32);
    wb(1, 8'h10, 4'hf, 32'h21);
    settle;
    chk({card_supply_out, supply_refused}, 4'h1);
    wb(1, 8'h10, 4'hf, 32'h31);
    @(posedge clk);
    {force_class_write, force_class_bits} <= 5'h12;
    @(posedge clk);
    force_class_write <= 1'b0;
    wb(1, 8'h10, 4'hf, 0);
    settle;
    chk(card_supply_out, 3'h3);
    reint;
    settle;
    chk(card_supply_out, 3'h0);
  endtask
  task t_clock;
    busy <= 1'b0;
    settle;
    chk(card_clk_stop, 0);
    host_clk_stop_prep <= 1'b1;
    settle;
    chk({card_clk_stop, card_clk_en}, 2'b10);
    host_clk_stop_prep <= 1'b0;
    wb(1, 8'h10, 4'h1, 32'h80);
    settle;
    chk(card_clk_stop, 1);
    {clock_control_enable, clock_slow_select} <= 2'b11;
    settle;
    k = 0;
    repeat (32) @(posedge clk) k += int'(card_clk_en === 1'b1);
    chk({card_clk_slow, card_clk_stop, k[5:0]}, 8'h82);
  endtask
  initial
  begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, standard_video_model_disable} = 0;
    {force_class_write, card_reinterrogate, clock_control_enable} = 0;
    {clock_slow_select, host_clk_stop_prep, wb_adr_i, wb_sel_i} = 0;
    {force_class_bits, wb_dat_i, bad_count, n_tests} = 0;
    card_class = 4'h2;
    busy = 1'b1;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    standard_video_model_disable <= 1'b0;
    t_supply;
    t_clock;
    end_sim;
  end
endmodule
